/* File: design/apc_pkg.sv */
// Purpose: Shared constants for the analog pin configuration block.
// Assumes: AXI4-Lite register access with 32-bit data words.
// Notes:   Offsets are byte addresses of aligned words.
package apc_pkg;

	localparam int          APC_NPINS         = 16;
	localparam int          APC_ADDR_W        = 4;
	localparam logic [3:0]  APC_OFS_FIRST     = 4'h0;
	localparam logic [3:0]  APC_OFS_SECOND    = 4'h4;
	localparam logic [3:0]  APC_OFS_DISABLE   = 4'h8;
	localparam logic [3:0]  APC_OFS_STATUS    = 4'hc;
	localparam logic [15:0] APC_SEL_RESET     = 16'h0000;
	localparam int          APC_DIS_FIRST_BIT = 0;
	localparam int          APC_DIS_SECOND_BIT = 1;
	localparam logic [1:0]  APC_DIS_RESET     = 2'h0;
	localparam logic [1:0]  APC_RESP_OKAY     = 2'h0;
	localparam logic [1:0]  APC_RESP_SLVERR   = 2'h2;

endpackage

/* File: design/apc_analog_pin_config.sv */
// Purpose: Per-pin analog/digital mode selection for sixteen shared pins.
// Assumes: pin_level comes from pads, outside the clock domain.
// Notes:   Disabled converter does not sample; its mux is grounded too.
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module apc_analog_pin_config #(
	parameter int NUM_INPUTS    = 16,
	parameter bit TWO_CONVERTERS = 1'b1
) (
	input  wire logic                           clk,
	input  wire logic                           resetn,
	input  wire logic [apc_pkg::APC_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [31:0]                    s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [apc_pkg::APC_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic [31:0]                         s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	input  wire logic [15:0]                    pin_level,
	output logic [15:0]                         port_read_data,
	output logic [15:0]                         port_read_enable,
	output logic [15:0]                         first_mux_to_ground,
	output logic [15:0]                         second_mux_to_ground
);
	import apc_pkg::*;

	// Channels that physically exist; the checks use it to leave absent pins alone.
	localparam logic [15:0] PRESENT_MASK = 16'((32'h1 << NUM_INPUTS) - 32'h1);

	logic [15:0] first_converter_pin_select_r;
	logic [15:0] second_converter_pin_select_r;
	logic [1:0]  converter_module_disable_r;
	logic [15:0] pin_sync1_r;
	logic [15:0] pin_sync2_r;
	logic [15:0] digital_mode;
	logic [15:0] present;
	logic [15:0] first_dig;
	logic [15:0] second_dig;
	logic        aw_held_r;
	logic        w_held_r;
	logic [3:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        do_write;
	logic [31:0] wr_mask;

	// Write address and data are latched independently, in either order.
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
	assign do_write      = aw_held_r && w_held_r;
	assign wr_mask       = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= 4'h0;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_r <= 1'b0;
			end
		end
	end

	// Write response: one cycle after both halves are in, OKAY or SLVERR.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= APC_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			if (awaddr_r == APC_OFS_FIRST || awaddr_r == APC_OFS_SECOND ||
			    awaddr_r == APC_OFS_DISABLE || awaddr_r == APC_OFS_STATUS) begin
				s_axi_bresp <= APC_RESP_OKAY;
			end else begin
				s_axi_bresp <= APC_RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register stores; all sixteen bits stay writable regardless of variant.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			first_converter_pin_select_r  <= APC_SEL_RESET;
			second_converter_pin_select_r <= APC_SEL_RESET;
			converter_module_disable_r    <= APC_DIS_RESET;
		end else if (do_write) begin
			if (awaddr_r == APC_OFS_FIRST) begin
				first_converter_pin_select_r <= (first_converter_pin_select_r & ~wr_mask[15:0])
					| (wdata_r[15:0] & wr_mask[15:0]);
			end else if (awaddr_r == APC_OFS_SECOND) begin
				second_converter_pin_select_r <= (second_converter_pin_select_r & ~wr_mask[15:0])
					| (wdata_r[15:0] & wr_mask[15:0]);
			end else if (awaddr_r == APC_OFS_DISABLE && wstrb_r[0]) begin
				converter_module_disable_r <= wdata_r[1:0];
			end
		end
	end

	// Read channel: registered data, status word shows effective pin modes.
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= APC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= APC_RESP_OKAY;
			if (s_axi_araddr == APC_OFS_FIRST) begin
				s_axi_rdata <= {16'h0000, first_converter_pin_select_r};
			end else if (s_axi_araddr == APC_OFS_SECOND) begin
				s_axi_rdata <= {16'h0000, second_converter_pin_select_r};
			end else if (s_axi_araddr == APC_OFS_DISABLE) begin
				s_axi_rdata <= {30'h0000_0000, converter_module_disable_r};
			end else if (s_axi_araddr == APC_OFS_STATUS) begin
				s_axi_rdata <= {16'h0000, digital_mode};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= APC_RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Pad levels pass two flip-flops before any gating reads them.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_sync1_r <= 16'h0000;
			pin_sync2_r <= 16'h0000;
		end else begin
			pin_sync1_r <= pin_level;
			pin_sync2_r <= pin_sync1_r;
		end
	end

	// Per-channel mode: disabled converter counts as digital; both must agree.
	for (genvar x = 0; x < APC_NPINS; x++) begin : g_pin
		assign present[x]    = (x < NUM_INPUTS);
		assign first_dig[x]  = converter_module_disable_r[APC_DIS_FIRST_BIT]
			|| first_converter_pin_select_r[x];
		assign second_dig[x] = !TWO_CONVERTERS
			|| converter_module_disable_r[APC_DIS_SECOND_BIT]
			|| second_converter_pin_select_r[x];
		assign digital_mode[x] = !present[x] || (first_dig[x] && second_dig[x]);
		assign first_mux_to_ground[x]  = present[x] && first_dig[x];
		assign second_mux_to_ground[x] = present[x] && second_dig[x];
	end

	// Read path enabled only in digital mode; analog pins read zero.
	assign port_read_enable = digital_mode;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			port_read_data <= 16'h0000;
		end else begin
			port_read_data <= pin_sync2_r & digital_mode;
		end
	end

	// Checks.
	property p_analog_reads_zero;
		@(posedge clk) disable iff (!resetn)
		(port_read_data & ~$past(digital_mode)) == 16'h0000;
	endproperty
	a_analog_reads_zero: assert property (p_analog_reads_zero)
		else $error("Analog pin read returned one.");

	property p_disable_forces_digital;
		@(posedge clk) disable iff (!resetn)
		(converter_module_disable_r == 2'h3) |-> (port_read_enable == 16'hffff);
	endproperty
	a_disable_forces_digital: assert property (p_disable_forces_digital)
		else $error("Disabled converter left a pin analog.");

	property p_both_needed;
		@(posedge clk) disable iff (!resetn)
		(TWO_CONVERTERS && converter_module_disable_r == 2'h0) |-> (digital_mode ==
			((first_converter_pin_select_r & second_converter_pin_select_r) | ~PRESENT_MASK));
	endproperty
	a_both_needed: assert property (p_both_needed)
		else $error("Pin digital without both selects.");

	property p_ground_when_digital;
		@(posedge clk) disable iff (!resetn)
		!converter_module_disable_r[APC_DIS_FIRST_BIT]
			|-> (first_mux_to_ground == (first_converter_pin_select_r & PRESENT_MASK));
	endproperty
	a_ground_when_digital: assert property (p_ground_when_digital)
		else $error("Mux grounding mismatches select bits.");

	sequence s_first_write;
		do_write && awaddr_r == APC_OFS_FIRST && wstrb_r == 4'hf;
	endsequence
	property p_write_next_cycle;
		@(posedge clk) disable iff (!resetn)
		s_first_write |=> (first_converter_pin_select_r == $past(wdata_r[15:0]));
	endproperty
	a_write_next_cycle: assert property (p_write_next_cycle)
		else $error("Select write not applied next cycle.");

	property p_reset_analog;
		@(posedge clk) $rose(resetn) |-> (first_converter_pin_select_r == 16'h0000)
			&& (second_converter_pin_select_r == 16'h0000);
	endproperty
	a_reset_analog: assert property (p_reset_analog)
		else $error("Selects not clear after reset.");

	property p_absent_no_effect;
		@(posedge clk) disable iff (!resetn)
		(((first_mux_to_ground | second_mux_to_ground) & ~PRESENT_MASK) == 16'h0000)
			&& ((port_read_enable & ~PRESENT_MASK) == ~PRESENT_MASK);
	endproperty
	a_absent_no_effect: assert property (p_absent_no_effect)
		else $error("Absent channel steered its mux.");

	property p_analog_blocks_read;
		@(posedge clk) disable iff (!resetn)
		(!first_converter_pin_select_r[0] && !converter_module_disable_r[0])
			|-> !port_read_enable[0] ##1 !port_read_data[0];
	endproperty
	a_analog_blocks_read: assert property (p_analog_blocks_read)
		else $error("Analog pin read path not blocked.");

	property p_second_ground;
		@(posedge clk) disable iff (!resetn)
		(TWO_CONVERTERS && !converter_module_disable_r[APC_DIS_SECOND_BIT])
			|-> (second_mux_to_ground == (second_converter_pin_select_r & PRESENT_MASK));
	endproperty
	a_second_ground: assert property (p_second_ground)
		else $error("Second mux grounding mismatches select bits.");

	property p_disable_grounds_first;
		@(posedge clk) disable iff (!resetn)
		converter_module_disable_r[APC_DIS_FIRST_BIT]
			|-> (first_mux_to_ground == PRESENT_MASK);
	endproperty
	a_disable_grounds_first: assert property (p_disable_grounds_first)
		else $error("Disabled converter left its mux on a pin.");

	sequence s_second_write;
		do_write && awaddr_r == APC_OFS_SECOND && wstrb_r == 4'hf;
	endsequence
	property p_second_write_next_cycle;
		@(posedge clk) disable iff (!resetn)
		s_second_write |=> (second_converter_pin_select_r == $past(wdata_r[15:0]));
	endproperty
	a_second_write_next_cycle: assert property (p_second_write_next_cycle)
		else $error("Second select write not applied next cycle.");

	property p_reset_pins_analog;
		@(posedge clk) $rose(resetn) |-> (port_read_enable == ~PRESENT_MASK)
			&& (first_mux_to_ground == 16'h0000);
	endproperty
	a_reset_pins_analog: assert property (p_reset_pins_analog)
		else $error("Pins not analog after reset.");

	sequence s_status_read;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == APC_OFS_STATUS;
	endsequence
	property p_status_shows_mode;
		@(posedge clk) disable iff (!resetn)
		s_status_read |=> (s_axi_rdata[15:0] == $past(digital_mode));
	endproperty
	a_status_shows_mode: assert property (p_status_shows_mode)
		else $error("Status read differs from pin modes.");

endmodule

/* File: tb/apc_pad_model.sv */
// Purpose: Model of the external sources that present levels on the sixteen pads.
// Assumes: Every pad carries a source level, analog or digital.
// Notes:   The pads are never driven as digital outputs.
`timescale 1ns/1ps
module apc_pad_model (
	input  wire logic [15:0] source_level,
	output logic [15:0]      pin_level
);
	// Sources only present a level, so no output driver contends with them.
	assign pin_level = source_level;
endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the analog pin configuration block.
// Assumes: Twelve channels present, two converters, AXI4-Lite master.
// Notes:   Expected modes are rebuilt from the select words and disable bits.
`timescale 1ns/1ps
module testbench;
	import apc_pkg::*;
	localparam logic [15:0] PRES = 16'h0fff;
	logic        clk, resetn, awv, wv, bready, arv, rready, awready, wready;
	logic        bvalid, arready, rvalid;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, d, v;
	logic [1:0]  bresp, rresp, resp, dis;
	logic [15:0] pad, pins, rd_data, rd_en, mux1, mux2, s1, s2, en;
	int          seed = 90;
	int          err_total = 0;
	int          comparisons = 0;
	int          i, j;
	apc_analog_pin_config #(.NUM_INPUTS(12), .TWO_CONVERTERS(1'b1)) dut (.clk(clk),
		.resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pin_level(pins), .port_read_data(rd_data),
		.port_read_enable(rd_en), .first_mux_to_ground(mux1), .second_mux_to_ground(mux2));
	apc_pad_model pads (.source_level(pad), .pin_level(pins));
	// Clock of 40 ns period.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Expected enable and mux masks; a disabled converter counts as digital.
	function automatic logic [47:0] exp_pins(input logic [15:0] a, b, input logic [1:0] m);
		logic [15:0] d1, d2;
		d1 = a | {16{m[0]}};
		d2 = b | {16{m[1]}};
		return {(d1 & d2 & PRES) | ~PRES, d1 & PRES, d2 & PRES};
	endfunction
	task automatic cmp_pins(input logic [47:0] g, e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp_bus(input logic [33:0] g, e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Write cycle; each channel drops its valid once taken.
	task automatic wr(input logic [3:0] a, input logic [31:0] x, input logic [3:0] s);
		@(posedge clk);
		{awaddr, wdata, wstrb, awv, wv, bready} <= {a, x, s, 3'b111};
		forever begin
			@(posedge clk);
			if (awv && awready) awv <= 1'b0;
			if (wv && wready) wv <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		resp = bresp;
		bready <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		{araddr, arv, rready} <= {a, 2'b11};
		forever begin
			@(posedge clk);
			if (arv && arready) arv <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		{resp, d} = {rresp, rdata};
		rready <= 1'b0;
		#1;
	endtask
	task automatic chk_mode();
		cmp_pins({rd_en, mux1, mux2}, exp_pins(s1, s2, dis));
	endtask
	task automatic conclude();
		$display("counts: comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog well beyond the expected run length.
	initial begin
		#(40 * 40000);
		err_total++;
		conclude();
	end
	// Main sequence: reset, random and corner configurations, strobes, odd addresses.
	initial begin
		{resetn, awv, wv, bready, arv, rready, awaddr, araddr, wstrb, wdata} = '0;
		{pad, s1, s2, dis} = '0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		#1;
		chk_mode();
		rd(APC_OFS_SECOND);
		cmp_bus({resp, d}, {APC_RESP_OKAY, 32'h0});
		$display("test reset done");
		for (i = 0; i < 40; i++) begin
			for (j = 0; j < 3; j++) begin
				v = $random(seed);
				if (i < 4) v[15:0] = (i[0] ^ (j == 1)) ? 16'hffff : 16'h0;
				if (i < 4 && j == 2) v[1:0] = i[1:0];
				if (j == 0) s1 = v[15:0];
				if (j == 1) s2 = v[15:0];
				if (j == 2) dis = v[1:0];
				wr(4'(j * 4), v, 4'hf);
				cmp_bus({resp, 32'h0}, {APC_RESP_OKAY, 32'h0});
				chk_mode();
				rd(4'(j * 4));
				cmp_bus({resp, d}, {APC_RESP_OKAY, 16'h0, j == 2 ? {14'h0, dis} : v[15:0]});
			end
			en = 16'(exp_pins(s1, s2, dis) >> 32);
			@(posedge clk);
			pad <= 16'($random(seed));
			repeat (4) @(posedge clk);
			#1;
			cmp_pins({rd_data, 32'h0}, {pad & en, 32'h0});
			rd(APC_OFS_STATUS);
			cmp_bus({resp, d}, {APC_RESP_OKAY, 16'h0, en});
		end
		$display("test random configurations done");
		wr(APC_OFS_FIRST, 32'h0000_1234, 4'b0010);
		s1 = {8'h12, s1[7:0]};
		chk_mode();
		rd(APC_OFS_FIRST);
		cmp_bus({resp, d}, {APC_RESP_OKAY, 16'h0, s1});
		wr(APC_OFS_STATUS, 32'h0, 4'hf);
		cmp_bus({resp, 32'h0}, {APC_RESP_OKAY, 32'h0});
		en = 16'(exp_pins(s1, s2, dis) >> 32);
		rd(APC_OFS_STATUS);
		cmp_bus({resp, d}, {APC_RESP_OKAY, 16'h0, en});
		wr(4'h1, 32'hffff, 4'hf);
		cmp_bus({resp, 32'h0}, {APC_RESP_SLVERR, 32'h0});
		chk_mode();
		rd(4'h1);
		cmp_bus({resp, d}, {APC_RESP_SLVERR, 32'h0});
		$display("test strobes and odd addresses done");
		@(posedge clk);
		resetn <= 1'b0;
		{s1, s2, dis} = '0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		#1;
		chk_mode();
		rd(APC_OFS_FIRST);
		cmp_bus({resp, d}, {APC_RESP_OKAY, 32'h0});
		repeat (4) @(posedge clk);
		#1;
		cmp_pins({rd_data, 32'h0}, {pad & 16'(exp_pins(s1, s2, dis) >> 32), 32'h0});
		$display("test mid-run reset done");
		conclude();
	end
endmodule
